//--- hdl/cmbrf_map.vh
`ifndef CMBRF_MAP_VH
`define CMBRF_MAP_VH
// mode field codes
`define CMBRF_MODE_USR 5'h10
`define CMBRF_MODE_FIQ 5'h11
`define CMBRF_MODE_IRQ 5'h12
`define CMBRF_MODE_SVC 5'h13
`define CMBRF_MODE_ABT 5'h17
`define CMBRF_MODE_UND 5'h1b
`define CMBRF_MODE_SYS 5'h1f
// status word field positions
`define CMBRF_BIT_N 31
`define CMBRF_BIT_Z 30
`define CMBRF_BIT_C 29
`define CMBRF_BIT_V 28
`define CMBRF_BIT_I 7
`define CMBRF_BIT_F 6
`define CMBRF_BIT_T 5
`define CMBRF_MODE_MSB 4
`define CMBRF_SW_MASK 32'hf00000ff
`define CMBRF_SW_RST 32'h000000d3
// register port offsets
`define CMBRF_OFS_CSW 4'h0
`define CMBRF_OFS_SSW 4'h4
`define CMBRF_OFS_STAT 4'h8
`define CMBRF_OFS_PC 4'hc
// exception vectors
`define CMBRF_VEC_UND 32'h00000004
`define CMBRF_VEC_TRAP 32'h00000008
`define CMBRF_VEC_ABT 32'h00000010
`define CMBRF_VEC_IRQ 32'h00000018
`define CMBRF_VEC_FIQ 32'h0000001c
`define CMBRF_PC_RST 32'h00000000
// exception request bit positions
`define CMBRF_EXC_FIQ 0
`define CMBRF_EXC_IRQ 1
`define CMBRF_EXC_ABT 2
`define CMBRF_EXC_UND 3
`define CMBRF_EXC_TRAP 4
// fetch steps and register indices
`define CMBRF_STEP_FULL 32'h00000004
`define CMBRF_STEP_CMP 32'h00000002
`define CMBRF_IDX_PC 4'hf
`define CMBRF_IDX_LINK 4'he
`define CMBRF_IDX_SP 4'hd
// access sizes
`define CMBRF_SZ_BYTE 2'h0
`define CMBRF_SZ_HALF 2'h1
`define CMBRF_SZ_WORD 2'h2
`endif

//--- hdl/cmbrf_regfile.v
`include "cmbrf_map.vh"
module cmbrf_regfile
#(
  parameter NUM_SLOTS = 30,
  parameter NUM_SAVED = 5
)
(
  input wire clock,
  input wire rst_n,
  input wire [3:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [31:0] bus_rdata_ff,
  input wire fetch_valid,
  input wire [31:0] fetch_word,
  output wire [31:0] fetch_addr,
  output wire [31:0] exec_word,
  output wire exec_valid,
  output wire exec_go,
  input wire [3:0] rd_a_idx,
  input wire [3:0] rd_b_idx,
  output reg [31:0] rd_a_data_ff,
  output reg [31:0] rd_b_data_ff,
  input wire wr_en,
  input wire [3:0] wr_idx,
  input wire [31:0] wr_data,
  input wire flag_we,
  input wire [3:0] flag_nzcv,
  input wire state_we,
  input wire state_val,
  input wire [4:0] exc_req,
  input wire [31:0] exc_ret_addr,
  input wire exc_return,
  input wire exc_ret_load,
  input wire [31:0] exc_ret_pc,
  input wire mem_req,
  input wire [1:0] mem_size,
  input wire [1:0] mem_addr,
  output reg align_fault_ff,
  output wire [31:0] current_status_word
);

  // mode code to bank: 0 user/system, 1 fast, 2 irq, 3 svc, 4 abort, 5 undef
  function [2:0] bank_of;
    input [4:0] mode;
    begin
      case (mode)
        `CMBRF_MODE_FIQ: bank_of = 3'h1;
        `CMBRF_MODE_IRQ: bank_of = 3'h2;
        `CMBRF_MODE_SVC: bank_of = 3'h3;
        `CMBRF_MODE_ABT: bank_of = 3'h4;
        `CMBRF_MODE_UND: bank_of = 3'h5;
        default: bank_of = 3'h0;
      endcase
    end
  endfunction

  // logical index plus bank to physical slot 0..29
  function [4:0] phys_of;
    input [3:0] idx;
    input [2:0] bank;
    begin
      if (idx < 4'h8)
        phys_of = {1'b0, idx};
      else if (idx < `CMBRF_IDX_SP)
        phys_of = (bank == 3'h1) ? ({1'b0, idx} + 5'h05) : {1'b0, idx};
      // slots 18 up: one index 13/14 pair per bank
      else
        phys_of = 5'h12 + {1'b0, bank, 1'b0} + {4'h0, idx[0] ^ 1'b1};
    end
  endfunction

  // condition field check against flags
  function cond_ok;
    input [3:0] cond;
    input [3:0] f;
    begin
      case (cond)
        4'h0: cond_ok = f[2];
        4'h1: cond_ok = ~f[2];
        4'h2: cond_ok = f[1];
        4'h3: cond_ok = ~f[1];
        4'h4: cond_ok = f[3];
        4'h5: cond_ok = ~f[3];
        4'h6: cond_ok = f[0];
        4'h7: cond_ok = ~f[0];
        4'h8: cond_ok = f[1] & ~f[2];
        4'h9: cond_ok = ~f[1] | f[2];
        4'ha: cond_ok = f[3] == f[0];
        4'hb: cond_ok = f[3] != f[0];
        4'hc: cond_ok = ~f[2] & (f[3] == f[0]);
        4'hd: cond_ok = f[2] | (f[3] != f[0]);
        4'he: cond_ok = 1'b1;
        default: cond_ok = 1'b0;
      endcase
    end
  endfunction

  // 30 banked/unbanked slots plus the counter make 31 general registers
  reg [31:0] gp_ff [0:NUM_SLOTS-1];
  reg [31:0] ssw_ff [0:NUM_SAVED-1];
  reg [31:0] csw_ff;
  reg [31:0] pc_ff;
  reg dec_valid_ff;
  reg [31:0] dec_word_ff;
  reg exe_valid_ff;
  reg [31:0] exe_word_ff;
  reg exe_go_ff;
  reg align_sticky_ff;
  reg [1:0] irq_meta_ff;
  reg [1:0] irq_sync_ff;
  reg [31:0] nxt_csw;
  reg [31:0] nxt_pc;
  reg flush;
  reg take;
  reg [4:0] tgt_mode;
  reg [31:0] tgt_vec;
  reg misalign;
  integer i;

  // bank change reaches the read ports one edge after the mode write
  wire [2:0] cur_bank = bank_of(csw_ff[`CMBRF_MODE_MSB:0]);
  wire [2:0] tgt_bank = bank_of(tgt_mode);
  wire [3:0] flags = csw_ff[`CMBRF_BIT_N:`CMBRF_BIT_V];
  wire cmp_state = csw_ff[`CMBRF_BIT_T];
  wire [31:0] link_cur = gp_ff[phys_of(`CMBRF_IDX_LINK, cur_bank)];
  // user and system have no saved word: return keeps the status word
  wire [31:0] ssw_cur = (cur_bank == 3'h0) ? csw_ff : ssw_ff[cur_bank - 3'h1];
  wire [4:0] req_now = {exc_req[4:2], irq_sync_ff};
  wire gp_write = wr_en & (wr_idx != `CMBRF_IDX_PC);
  wire pc_write = wr_en & (wr_idx == `CMBRF_IDX_PC);
  wire stat_clr = bus_wr & (bus_addr == `CMBRF_OFS_STAT) & bus_wdata[0];

  // one read port: counter at index 15, else the banked slot
  function [31:0] port_read;
    input [3:0] idx;
    begin
      if (idx == `CMBRF_IDX_PC)
        port_read = pc_ff;
      else
        port_read = gp_ff[phys_of(idx, cur_bank)];
    end
  endfunction

  assign fetch_addr = pc_ff;
  assign exec_word = exe_word_ff;
  assign exec_valid = exe_valid_ff;
  assign exec_go = exe_go_ff;
  assign current_status_word = csw_ff;

  // exception selection: abort, fast, normal, undefined, trap
  // requests are levels: an abort, undefined or trap request left high after entry enters again
  always @*
  begin
    take = 1'b1;
    tgt_mode = `CMBRF_MODE_SVC;
    tgt_vec = `CMBRF_VEC_TRAP;
    if (req_now[`CMBRF_EXC_ABT])
    begin
      tgt_mode = `CMBRF_MODE_ABT;
      tgt_vec = `CMBRF_VEC_ABT;
    end
    else if (req_now[`CMBRF_EXC_FIQ] & ~csw_ff[`CMBRF_BIT_F])
    begin
      tgt_mode = `CMBRF_MODE_FIQ;
      tgt_vec = `CMBRF_VEC_FIQ;
    end
    else if (req_now[`CMBRF_EXC_IRQ] & ~csw_ff[`CMBRF_BIT_I])
    begin
      tgt_mode = `CMBRF_MODE_IRQ;
      tgt_vec = `CMBRF_VEC_IRQ;
    end
    else if (req_now[`CMBRF_EXC_UND])
    begin
      tgt_mode = `CMBRF_MODE_UND;
      tgt_vec = `CMBRF_VEC_UND;
    end
    else if (!req_now[`CMBRF_EXC_TRAP])
      take = 1'b0;
  end

  // next status word and program counter
  always @*
  begin
    nxt_csw = csw_ff;
    nxt_pc = pc_ff;
    flush = 1'b0;
    // entry outranks return; other writes that cycle are dropped
    if (take)
    begin
      // handlers start full-width with normal interrupts masked
      nxt_csw[`CMBRF_MODE_MSB:0] = tgt_mode;
      nxt_csw[`CMBRF_BIT_T] = 1'b0;
      nxt_csw[`CMBRF_BIT_I] = 1'b1;
      if (tgt_mode == `CMBRF_MODE_FIQ)
        nxt_csw[`CMBRF_BIT_F] = 1'b1;
      nxt_pc = tgt_vec;
      flush = 1'b1;
    end
    else if (exc_return)
    begin
      nxt_csw = ssw_cur;
      nxt_pc = exc_ret_load ? exc_ret_pc : link_cur;
      flush = 1'b1;
    end
    else
    begin
      // reserved status bits always read back zero
      if (bus_wr && bus_addr == `CMBRF_OFS_CSW)
        nxt_csw = bus_wdata & `CMBRF_SW_MASK;
      // flag and state writes override a same-cycle bus write
      if (flag_we)
        nxt_csw[`CMBRF_BIT_N:`CMBRF_BIT_V] = flag_nzcv;
      if (state_we)
        nxt_csw[`CMBRF_BIT_T] = state_val;
      if (pc_write)
      begin
        nxt_pc = wr_data;
        flush = 1'b1;
      end
      else if (fetch_valid)
        nxt_pc = pc_ff + (cmp_state ? `CMBRF_STEP_CMP : `CMBRF_STEP_FULL);
    end
  end

  // data alignment check
  always @*
  begin
    case (mem_size)
      `CMBRF_SZ_BYTE: misalign = 1'b0;
      `CMBRF_SZ_HALF: misalign = mem_addr[0];
      `CMBRF_SZ_WORD: misalign = mem_addr != 2'h0;
      // illegal size code always faults
      default: misalign = 1'b1;
    endcase
  end

  // interrupt lines arrive from outside this clock
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_meta_ff <= 2'h0;
      irq_sync_ff <= 2'h0;
    end
    else
    begin
      irq_meta_ff <= exc_req[1:0];
      irq_sync_ff <= irq_meta_ff;
    end
  end

  // status word, counter, pipeline, alignment
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      csw_ff <= `CMBRF_SW_RST;
      pc_ff <= `CMBRF_PC_RST;
      dec_valid_ff <= 1'b0;
      dec_word_ff <= 32'h00000000;
      exe_valid_ff <= 1'b0;
      exe_word_ff <= 32'h00000000;
      exe_go_ff <= 1'b0;
      align_fault_ff <= 1'b0;
      align_sticky_ff <= 1'b0;
    end
    else
    begin
      csw_ff <= nxt_csw;
      pc_ff <= nxt_pc;
      if (flush)
      begin
        dec_valid_ff <= 1'b0;
        exe_valid_ff <= 1'b0;
        exe_go_ff <= 1'b0;
      end
      else
      begin
        dec_valid_ff <= fetch_valid;
        if (fetch_valid)
          dec_word_ff <= cmp_state ? {16'h0000, fetch_word[15:0]} : fetch_word;
        exe_valid_ff <= dec_valid_ff;
        exe_word_ff <= dec_word_ff;
        // compact words carry no condition field, so they always go
        exe_go_ff <= dec_valid_ff & (cmp_state | cond_ok(dec_word_ff[31:28], flags));
      end
      align_fault_ff <= mem_req & misalign;
      // a new fault beats a clear in the same cycle
      if (mem_req & misalign)
        align_sticky_ff <= 1'b1;
      else if (stat_clr)
        align_sticky_ff <= 1'b0;
    end
  end

  // banked register array and saved status words
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < NUM_SLOTS; i = i + 1)
        gp_ff[i] <= 32'h00000000;
      for (i = 0; i < NUM_SAVED; i = i + 1)
        ssw_ff[i] <= 32'h00000000;
    end
    else if (take)
    begin
      gp_ff[phys_of(`CMBRF_IDX_LINK, tgt_bank)] <= exc_ret_addr;
      ssw_ff[tgt_bank - 3'h1] <= csw_ff;
    end
    else if (!exc_return)
    begin
      if (gp_write)
        gp_ff[phys_of(wr_idx, cur_bank)] <= wr_data;
      // user and system own no saved word, writes there are dropped
      if (bus_wr && bus_addr == `CMBRF_OFS_SSW && cur_bank != 3'h0)
        ssw_ff[cur_bank - 3'h1] <= bus_wdata & `CMBRF_SW_MASK;
    end
  end

  // two read ports, 16 visible registers per mode
  // no write bypass: same-edge reads see the old value
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_a_data_ff <= 32'h00000000;
      rd_b_data_ff <= 32'h00000000;
    end
    else
    begin
      rd_a_data_ff <= port_read(rd_a_idx);
      rd_b_data_ff <= port_read(rd_b_idx);
    end
  end

  // register port read data, valid only the cycle after the strobe
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      bus_rdata_ff <= 32'h00000000;
    else if (!bus_rd)
      bus_rdata_ff <= 32'h00000000;
    else
    begin
      case (bus_addr)
        `CMBRF_OFS_CSW: bus_rdata_ff <= csw_ff;
        // saved word reads zero where the mode owns none
        `CMBRF_OFS_SSW: bus_rdata_ff <= (cur_bank == 3'h0) ? 32'h00000000 : ssw_cur;
        `CMBRF_OFS_STAT: bus_rdata_ff <= {29'h0, exe_valid_ff, dec_valid_ff, align_sticky_ff};
        `CMBRF_OFS_PC: bus_rdata_ff <= pc_ff;
        default: bus_rdata_ff <= 32'h00000000;
      endcase
    end
  end

endmodule

//--- tb/cmbrf_fetch_src.sv
module cmbrf_fetch_src
(
  input wire clock,
  input wire en,
  input wire slow,
  input wire [3:0] cond,
  output reg fetch_valid,
  output reg [31:0] fetch_word
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [27:0] cnt_ff = '0;
  initial fetch_valid = 1'h0;
  initial fetch_word = 32'h0;
  always @(posedge clock)
  begin
    fetch_valid <= en && (!slow || cnt_ff[0]);
    // condition on top of every word, line toggles when idle
    fetch_word <= en ? {cond, cnt_ff} : ~fetch_word;
    cnt_ff <= cnt_ff + 28'h1;
  end
endmodule

//--- tb/cmbrf_properties.sv
module cmbrf_properties
(
  input wire clock,
  input wire rst_n,
  input wire fetch_valid,
  input wire [31:0] fetch_addr,
  input wire exec_valid,
  input wire [3:0] rd_a_idx,
  input wire [31:0] rd_a_data_ff,
  input wire wr_en,
  input wire [4:0] exc_req,
  input wire exc_return,
  input wire exc_ret_load,
  input wire [31:0] exc_ret_pc,
  input wire mem_req,
  input wire [1:0] mem_size,
  input wire [1:0] mem_addr,
  input wire align_fault_ff,
  input wire [31:0] current_status_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  wire masked = current_status_word[7:6] == 2'h3;
  property p_sw_mask;
    (current_status_word & 32'h0fffff00) == 32'h0;
  endproperty
  property p_align_hit;
    mem_req && (mem_size == 2'h1 && mem_addr[0] || mem_size == 2'h2 && mem_addr != 2'h0)
      |=> align_fault_ff;
  endproperty
  property p_align_quiet;
    !mem_req || mem_size == 2'h0 |=> !align_fault_ff;
  endproperty
  property p_abort;
    exc_req[2] && !exc_return |=> current_status_word[4:0] == 5'h17
      && current_status_word[7] && !current_status_word[5] && fetch_addr == 32'h10;
  endproperty
  property p_flush;
    exc_req[2] && !exc_return |=> !exec_valid;
  endproperty
  property p_trap;
    exc_req == 5'h10 && !exc_return && masked |=> current_status_word[4:0] == 5'h13
      && fetch_addr == 32'h8;
  endproperty
  property p_pc_read;
    rd_a_idx == 4'hf |=> rd_a_data_ff == $past(fetch_addr);
  endproperty
  property p_step;
    fetch_valid && exc_req == 5'h0 && !exc_return && !wr_en && masked
      |=> fetch_addr == $past(fetch_addr) + ($past(current_status_word[5]) ? 32'h2 : 32'h4);
  endproperty
  property p_ret_load;
    exc_return && exc_ret_load && exc_req == 5'h0 && masked |=> fetch_addr == $past(exc_ret_pc);
  endproperty
  a_sw_mask: assert property (p_sw_mask) else $error("reserved bits set");
  a_align_hit: assert property (p_align_hit) else $error("fault missed");
  a_align_quiet: assert property (p_align_quiet) else $error("false fault");
  a_abort: assert property (p_abort) else $error("abort entry wrong");
  a_flush: assert property (p_flush) else $error("no flush");
  a_trap: assert property (p_trap) else $error("trap entry wrong");
  a_pc_read: assert property (p_pc_read) else $error("index 15 wrong");
  a_step: assert property (p_step) else $error("fetch step wrong");
  a_ret_load: assert property (p_ret_load) else $error("restore pc wrong");
  c_abort: cover property (exc_req[2]);
  c_compact: cover property (fetch_valid && current_status_word[5]);
  c_fault: cover property (align_fault_ff);
endmodule

//--- tb/cpu_mode_banked_regfile_bench.sv
module cpu_mode_banked_regfile_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = '0, rst_n = '0, bus_wr = '0, bus_rd = '0, wr_en = '0, flag_we = '0;
  logic state_we = '0, state_val = '0, exc_return = '0, exc_ret_load = '0, mem_req = '0;
  logic en = '0, slow = '0, zf = '0, cmp = '0, pl = '0, stk = '0;
  logic [3:0] bus_addr = '0, rd_a_idx = 4'hf, wr_idx = '0, flag_nzcv = '0, cnd = 4'he;
  logic [3:0] rd_b_idx = 4'hf;
  logic [31:0] bus_wdata = '0, wr_data = '0, exc_ret_addr = '0, exc_ret_pc = '0, pcx = '0;
  logic [4:0] exc_req = '0;
  logic [1:0] mem_size = '0, mem_addr = '0;
  logic [32:0] h0 = '0, h1 = '0;
  logic [31:0] a [15];
  logic [31:0] b [15];
  logic [3:0] ct [4] = '{4'h0, 4'h1, 4'he, 4'hf};
  wire fetch_valid, exec_valid, exec_go, align_fault_ff;
  wire [31:0] rd_b_data_ff;
  wire [31:0] fetch_word, fetch_addr, exec_word, bus_rdata_ff, rd_a_data_ff, current_status_word;
  int seed = 32'h8951978a;
  int failures = 0;
  int tests_run = 0;
  int i;
  int k;
  cmbrf_fetch_src src (.clock, .en, .slow, .cond(cnd), .fetch_valid, .fetch_word);
  cmbrf_regfile dut (.clock, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_ff,
    .fetch_valid, .fetch_word, .fetch_addr, .exec_word, .exec_valid, .exec_go, .rd_a_idx,
    .rd_b_idx, .rd_a_data_ff, .rd_b_data_ff, .wr_en, .wr_idx, .wr_data, .flag_we,
    .flag_nzcv, .state_we, .state_val, .exc_req, .exc_ret_addr, .exc_return, .exc_ret_load,
    .exc_ret_pc, .mem_req, .mem_size, .mem_addr, .align_fault_ff, .current_status_word);
  always #25 clock = ~clock;
  function logic go_exp(input logic [3:0] c);
    return cmp || c == 4'he || (c == 4'h0 && zf) || (c == 4'h1 && !zf);
  endfunction
  function logic mis(input logic [1:0] s, input logic [1:0] ad);
    return s == 2'h3 || (s == 2'h1 && ad[0]) || (s == 2'h2 && ad != 2'h0);
  endfunction
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bwr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clock);
    bus_addr <= ad;
    bus_wdata <= d;
    bus_wr <= 1'h1;
    @(posedge clock);
    bus_wr <= 1'h0;
  endtask
  task brd(input logic [3:0] ad, input logic [31:0] e);
    @(posedge clock);
    bus_addr <= ad;
    bus_rd <= 1'h1;
    @(posedge clock);
    bus_rd <= 1'h0;
    @(negedge clock);
    chk(bus_rdata_ff, e);
  endtask
  task wrr(input logic [3:0] x, input logic [31:0] d);
    @(posedge clock);
    wr_en <= 1'h1;
    wr_idx <= x;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'h0;
  endtask
  task rrd(input logic [3:0] x, input logic [31:0] e);
    @(posedge clock);
    rd_a_idx <= x;
    rd_b_idx <= x;
    @(posedge clock);
    @(negedge clock);
    chk(rd_a_data_ff, e);
    chk(rd_b_data_ff, e);
  endtask
  task exc(input logic [4:0] rq, input logic [4:0] m, input logic [31:0] v);
    logic [31:0] base;
    logic [31:0] ra;
    logic [31:0] sw;
    int n;
    base = rq[1:0] != 2'h0 ? 32'h1f : 32'hdf;
    ra = $random(seed);
    bwr(4'h0, base);
    @(posedge clock);
    exc_ret_addr <= ra;
    exc_ret_pc <= ~ra;
    exc_ret_load <= rq[4];
    exc_req <= rq;
    // interrupts pass a synchroniser, others are taken at once
    repeat (rq[1:0] != 2'h0 ? 4 : 1) @(posedge clock);
    exc_req <= '0;
    n = 0;
    @(negedge clock);
    while (current_status_word[4:0] !== m && n < 8)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 8)
    begin
      failures++;
      end_sim;
    end
    sw = (base & 32'h40) | 32'h80 | (m == 5'h11 ? 32'h40 : 32'h0) | m;
    chk(current_status_word, sw);
    chk(fetch_addr, v);
    brd(4'h4, base);
    rrd(4'he, ra);
    @(posedge clock);
    exc_return <= 1'h1;
    @(posedge clock);
    exc_return <= 1'h0;
    pcx = rq[4] ? ~ra : ra;
    @(negedge clock);
    chk(current_status_word, base);
    rrd(4'hf, pcx);
    $display("exception test done");
  endtask
  always @(negedge clock)
  begin
    if (pl)
    begin
      chk(32'(exec_valid), 32'(h1[32]));
      if (h1[32])
        chk(exec_word, cmp ? {16'h0000, h1[15:0]} : h1[31:0]);
      if (h1[32])
        chk(32'(exec_go), 32'(go_exp(h1[31:28])));
      pcx = pcx + (fetch_valid ? (cmp ? 32'h2 : 32'h4) : 32'h0);
    end
    h1 = h0;
    h0 = {fetch_valid, fetch_word};
  end
  initial
  begin
    for (i = 0; i < 15; i++)
    begin
      a[i] = $random(seed);
      b[i] = $random(seed);
    end
    repeat (3) @(posedge clock);
    rst_n <= 1'h1;
    brd(4'h0, 32'hd3);
    brd(4'hc, 32'h0);
    brd(4'h2, 32'h0);
    bwr(4'h0, 32'hffffffff);
    brd(4'h0, 32'hf00000ff);
    $display("status test done");
    bwr(4'h0, 32'hd3);
    for (i = 0; i < 15; i++)
      wrr(4'(i), a[i]);
    bwr(4'h0, 32'hd1);
    bwr(4'h4, 32'hffffffff);
    brd(4'h4, 32'hf00000ff);
    for (i = 8; i < 15; i++)
      wrr(4'(i), b[i]);
    for (i = 0; i < 15; i++)
      rrd(4'(i), i < 8 ? a[i] : b[i]);
    bwr(4'h0, 32'hdf);
    brd(4'h4, 32'h0);
    for (i = 0; i < 15; i++)
      rrd(4'(i), i < 13 ? a[i] : 32'h0);
    bwr(4'h0, 32'hd3);
    for (i = 13; i < 15; i++)
      rrd(4'(i), a[i]);
    $display("bank test done");
    exc(5'h01, 5'h11, 32'h1c);
    exc(5'h02, 5'h12, 32'h18);
    exc(5'h04, 5'h17, 32'h10);
    exc(5'h08, 5'h1b, 32'h04);
    exc(5'h10, 5'h13, 32'h08);
    exc(5'h1c, 5'h17, 32'h10);
    bwr(4'h0, 32'hdf);
    pl = 1'h1;
    for (k = 0; k < 10; k++)
    begin
      @(posedge clock);
      flag_we <= 1'h1;
      flag_nzcv <= k[0] ? 4'h4 : 4'h0;
      state_we <= k == 8;
      state_val <= 1'h1;
      @(posedge clock);
      flag_we <= 1'h0;
      state_we <= 1'h0;
      zf <= k[0];
      cmp <= k >= 8;
      slow <= k[1];
      cnd <= ct[k[2:1]];
      en <= 1'h1;
      repeat (6) @(posedge clock);
      en <= 1'h0;
      repeat (5) @(posedge clock);
    end
    pl = 1'h0;
    @(negedge clock);
    chk(fetch_addr, pcx);
    $display("pipeline test done");
    for (k = 0; k < 24; k++)
    begin
      @(posedge clock);
      mem_req <= 1'h1;
      mem_size <= 2'(k % 4);
      mem_addr <= 2'($random(seed));
      @(posedge clock);
      mem_req <= 1'h0;
      @(negedge clock);
      chk(32'(align_fault_ff), 32'(mis(mem_size, mem_addr)));
      stk = stk | mis(mem_size, mem_addr);
    end
    brd(4'h8, 32'(stk));
    @(posedge clock);
    mem_req <= 1'h1;
    mem_size <= 2'h1;
    mem_addr <= 2'h1;
    bus_addr <= 4'h8;
    bus_wdata <= 32'h1;
    bus_wr <= 1'h1;
    @(posedge clock);
    mem_req <= 1'h0;
    bus_wr <= 1'h0;
    brd(4'h8, 32'h1);
    bwr(4'h8, 32'h1);
    brd(4'h8, 32'h0);
    $display("alignment test done");
    end_sim;
  end
endmodule
bind cmbrf_regfile cmbrf_properties props (.clock, .rst_n, .fetch_valid, .fetch_addr,
  .exec_valid, .rd_a_idx, .rd_a_data_ff, .wr_en, .exc_req, .exc_return, .exc_ret_load,
  .exc_ret_pc, .mem_req, .mem_size, .mem_addr, .align_fault_ff, .current_status_word);
